// >>> rtl/wdqa_qgen.sv
// Question counter and Markov chain forming the current question.
`timescale 1ns/1ps
module wdqa_qgen (
  input wire logic clk_in,
  input wire logic rst_n_in,
  wdqa_q_if.gen q_if
);
  import wdqa_pkg::*;

  typedef struct packed {
    logic [3:0] qcnt;
    logic [3:0] mkv;
  } wdqa_qgen_st_t;

  wdqa_qgen_st_t st_ff;
  wdqa_qgen_st_t nxt_st;
  logic [3:0] mkv_step;
  logic fb;

  always_comb begin
    case (q_if.poly_sel)
      2'h0: fb = st_ff.mkv[3] ^ st_ff.mkv[2]; // [RULE25]
      2'h1: fb = st_ff.mkv[3] ^ st_ff.mkv[1];
      2'h2: fb = st_ff.mkv[3] ^ st_ff.mkv[0];
      default: fb = st_ff.mkv[3] ^ st_ff.mkv[2] ^ st_ff.mkv[1];
    endcase
    if (st_ff.mkv == WDQA_MKV_RESET) begin
      mkv_step = WDQA_MKV_KICK; // [RULE16]
    end else begin
      mkv_step = {st_ff.mkv[2:0], fb};
    end
    nxt_st = st_ff;
    if (q_if.init) begin
      nxt_st.qcnt = WDQA_QST_RESET; // [RULE15]
      nxt_st.mkv = WDQA_MKV_RESET;
    end else if (q_if.advance) begin
      nxt_st.qcnt = st_ff.qcnt + 4'h1; // [RULE13]
      if (st_ff.qcnt == WDQA_QCNT_MAX) begin
        nxt_st.mkv = mkv_step; // [RULE14]
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_if.question = st_ff.qcnt ^ st_ff.mkv; // [RULE12]
endmodule

// >>> rtl/wdqa_ref.sv
// Reference answer byte from question, answer index and feedback select.
`timescale 1ns/1ps
module wdqa_ref (
  wdqa_q_if.refer q_if
);
  import wdqa_pkg::*;

  logic [7:0] base;
  logic [7:0] idx_mask;

  always_comb begin
    base = WDQA_REF_BASE;
    if (q_if.question[0]) begin
      base = base ^ WDQA_REF_Q0; // [RULE10]
    end
    if (q_if.question[1]) begin
      base = base ^ WDQA_REF_Q1;
    end
    if (q_if.question[2]) begin
      base = base ^ WDQA_REF_Q2;
    end
    if (q_if.question[3]) begin
      base = base ^ WDQA_REF_Q3;
    end
    case (q_if.ans_idx)
      2'h3: idx_mask = WDQA_REF_A3; // [RULE17]
      2'h2: idx_mask = WDQA_REF_A2;
      2'h1: idx_mask = WDQA_REF_A1;
      default: idx_mask = WDQA_REF_A0;
    endcase
    // Non-default feedback rotates the base; default reproduces the standard table
    case (q_if.fdbk_sel)
      2'h0: q_if.ref_byte = base ^ idx_mask; // [RULE25]
      2'h1: q_if.ref_byte = {base[6:0], base[7]} ^ idx_mask;
      2'h2: q_if.ref_byte = {base[5:0], base[7:6]} ^ idx_mask;
      default: q_if.ref_byte = {base[4:0], base[7:5]} ^ idx_mask;
    endcase
  end
endmodule

// >>> rtl/wdqa_top.sv
// Question-answer watchdog: answer checking, sequence control and status flags.
`timescale 1ns/1ps
module wdqa_top (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic seq_start_in,
  input wire logic win1_end_in,
  input wire logic win2_end_in,
  input wire logic ans_wr_in,
  input wire logic [7:0] ans_data_in,
  input wire logic [wdqa_pkg::WDQA_CLR_W-1:0] flag_clr_in,
  input wire logic [1:0] fdbk_sel_in,
  input wire logic [1:0] poly_sel_in,
  output logic [7:0] qa_index_out,
  output logic answer_error_flag_out,
  output logic timeout_flag_out,
  output logic bad_event_flag_out,
  output logic early_answer_flag_out,
  output logic sequence_error_flag_out,
  output logic fail_inc_out,
  output logic fail_dec_out,
  output logic seq_restart_out
);
  import wdqa_pkg::*;

  typedef struct packed {
    wdqa_state_t state;
    logic [1:0] ans_cnt;
    logic seq_bad;
    logic ans_err;
    logic tmo;
    logic early;
    logic seq_err;
    logic bad_flag;
    logic fail_inc;
    logic fail_dec;
    logic restart;
    logic advance;
    logic init;
    logic [1:0] fdbk;
    logic [1:0] poly;
    logic [7:0] index;
  } wdqa_top_st_t;

  wdqa_top_st_t st_ff;
  wdqa_top_st_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic byte_ok;
  logic seq_done;
  logic seq_good;

  wdqa_q_if q_if ();

  // Release of the asynchronous reset is retimed to the clock
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  wdqa_qgen u_qgen (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .q_if(q_if.gen)
  );

  wdqa_ref u_ref (
    .q_if(q_if.refer)
  );

  assign q_if.init = st_ff.init;
  assign q_if.advance = st_ff.advance;
  assign q_if.poly_sel = st_ff.poly;
  assign q_if.fdbk_sel = st_ff.fdbk;
  assign q_if.ans_idx = st_ff.ans_cnt;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fail_inc = 1'b0;
    nxt_st.fail_dec = 1'b0;
    nxt_st.restart = 1'b0;
    nxt_st.advance = 1'b0;
    nxt_st.init = 1'b0;
    byte_ok = (ans_data_in == q_if.ref_byte); // [RULE21]
    seq_done = 1'b0;
    seq_good = 1'b0;

    // Host clears first; hardware sets below override in the same cycle
    if (flag_clr_in[WDQA_CLR_ANSW_ERR]) begin
      nxt_st.ans_err = 1'b0; // [RULE19]
    end
    if (flag_clr_in[WDQA_CLR_TIMEOUT]) begin
      nxt_st.tmo = 1'b0;
    end
    if (flag_clr_in[WDQA_CLR_EARLY]) begin
      nxt_st.early = 1'b0;
    end
    if (flag_clr_in[WDQA_CLR_SEQ_ERR]) begin
      nxt_st.seq_err = 1'b0;
    end

    case (st_ff.state)
      WDQA_LONG: begin
        // Settings are frozen once the first sequence starts
        nxt_st.fdbk = fdbk_sel_in;
        nxt_st.poly = poly_sel_in;
        if (seq_start_in) begin // [RULE26]
          nxt_st.state = WDQA_WIN1;
          nxt_st.init = 1'b1; // [RULE15]
          nxt_st.ans_cnt = WDQA_CNT_START; // [RULE18]
          nxt_st.seq_bad = 1'b0;
        end
      end
      WDQA_WIN1: begin
        // Writes are taken from the first Window-1 cycle, no question read needed
        if (ans_wr_in) begin // [RULE8]
          if (!byte_ok) begin
            nxt_st.ans_err = 1'b1; // [RULE19]
            nxt_st.bad_flag = 1'b1; // [RULE4]
            nxt_st.seq_bad = 1'b1;
          end
          if (st_ff.ans_cnt == WDQA_CNT_LAST) begin
            nxt_st.early = 1'b1; // [RULE24]
            nxt_st.bad_flag = 1'b1;
            nxt_st.seq_bad = 1'b1;
            seq_done = 1'b1; // [RULE6]
          end else begin
            nxt_st.ans_cnt = st_ff.ans_cnt - 2'h1; // [RULE21]
          end
        end
        if (win1_end_in && !seq_done) begin // [RULE26]
          nxt_st.state = WDQA_WIN2;
          // Fewer than three bytes taken in Window-1 means wrong timing
          if (nxt_st.ans_cnt != WDQA_CNT_LAST) begin
            nxt_st.seq_err = 1'b1; // [RULE4]
            nxt_st.bad_flag = 1'b1;
            nxt_st.seq_bad = 1'b1;
          end
        end
      end
      WDQA_WIN2: begin
        if (ans_wr_in) begin
          if (!byte_ok) begin
            nxt_st.ans_err = 1'b1; // [RULE19]
            nxt_st.bad_flag = 1'b1; // [RULE4]
            nxt_st.seq_bad = 1'b1;
          end
          if (st_ff.ans_cnt == WDQA_CNT_LAST) begin
            seq_done = 1'b1; // [RULE6]
            seq_good = byte_ok && !st_ff.seq_bad; // [RULE3]
          end else begin
            // A late byte in Window-2 was already marked by the Window-1 end
            nxt_st.ans_cnt = st_ff.ans_cnt - 2'h1; // [RULE21]
          end
        end else if (win2_end_in) begin // [RULE26]
          nxt_st.tmo = 1'b1; // [RULE5]
          nxt_st.bad_flag = 1'b1;
          nxt_st.seq_bad = 1'b1;
          seq_done = 1'b1; // [RULE6]
        end
      end
      WDQA_GAP: begin
        // One idle cycle between the final byte and the next Window-1
        nxt_st.state = WDQA_WIN1; // [RULE7]
        nxt_st.restart = 1'b1;
        nxt_st.bad_flag = 1'b0;
        nxt_st.seq_bad = 1'b0;
        nxt_st.ans_cnt = WDQA_CNT_START; // [RULE18]
      end
      default: begin
        nxt_st.state = WDQA_LONG;
      end
    endcase

    if (seq_done) begin
      nxt_st.state = WDQA_GAP; // [RULE22]
      nxt_st.ans_cnt = WDQA_CNT_START;
      if (seq_good) begin
        nxt_st.fail_dec = 1'b1; // [RULE23]
        nxt_st.advance = 1'b1; // [RULE13]
      end else begin
        nxt_st.fail_inc = 1'b1; // [RULE5]
      end
    end

    // Status word tracks question and index; bit 6 and bit 7 read as zero
    nxt_st.index = 8'h00; // [RULE11]
    nxt_st.index[WDQA_IDX_QST_LSB +: 4] = q_if.question; // [RULE1]
    nxt_st.index[WDQA_IDX_CNT_LSB +: 2] = nxt_st.ans_cnt;
    nxt_st.index[WDQA_IDX_RSVD_BIT] = 1'b0;
  end

  // Only answer strobes, window-end and start pulses, flag clears and the Long Window selects touch this state, so unrelated accesses pass by
  always_ff @(posedge mclk_in or negedge rst_n) begin // [RULE9]
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.state <= WDQA_LONG;
      st_ff.ans_cnt <= WDQA_CNT_START;
      st_ff.fdbk <= WDQA_SEL_DEFAULT;
      st_ff.poly <= WDQA_SEL_DEFAULT;
      st_ff.index <= {2'h0, WDQA_CNT_START, WDQA_QST_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign qa_index_out = st_ff.index;
  assign answer_error_flag_out = st_ff.ans_err;
  assign timeout_flag_out = st_ff.tmo;
  assign bad_event_flag_out = st_ff.bad_flag;
  assign early_answer_flag_out = st_ff.early;
  assign sequence_error_flag_out = st_ff.seq_err;
  assign fail_inc_out = st_ff.fail_inc;
  assign fail_dec_out = st_ff.fail_dec;
  assign seq_restart_out = st_ff.restart;
endmodule

// >>> shared/wdqa_pkg.sv
// Constants and types for the question-answer watchdog block.
// Operation
// [RULE1] A 4-bit question is always readable in the status word's low nibble.
// [RULE2] Host sends the 32-bit answer as four byte writes, Answer-3 first.
// [RULE3] Good event needs four correct ordered bytes, three in Window-1, last in Window-2.
// [RULE4] Wrong byte value, wrong window or wrong order gives a bad event.
// [RULE5] Missing answers until Window-2 ends set timeout, bump fail count, restart; a non-final byte write in the Window-2 end cycle does none of these.
// [RULE6] A sequence ends on the Answer-0 write or when Window-2 expires; a non-final byte write in the Window-2 end cycle keeps it open until Answer-0.
// [RULE7] The next sequence begins one system clock cycle after the final byte.
// [RULE8] First three bytes are accepted from Window-1 start, question read not needed.
// [RULE9] Other register traffic between answer writes does not disturb detection.
// [RULE10] Reference bytes come only from the internal question.
// [RULE11] Status word: bit 6 reserved, bits 5-4 answer index, bits 3-0 question.
// [RULE12] Question combines a 4-bit question counter and a 4-bit Markov state.
// [RULE13] Question counter advances only on a good event.
// [RULE14] Markov chain steps when the question counter wraps from 1111 to 0000.
// [RULE15] Leaving the Long Window clears question counter and Markov chain.
// [RULE16] A Markov state of 0000 steps to 0001.
// [RULE17] A 2-bit answer counter with the question selects the reference byte.
// [RULE18] Each sequence starts with the answer counter at 2'b11.
// [RULE19] Answer error flag sets at once on a wrong byte, clears on host write-one.
// [RULE20] Host writes answers over SPI or the auxiliary I2C port.
// [RULE21] Each byte is compared with its reference; counter decrements down to zero.
// [RULE22] After Answer-0 a new sequence starts with the counter reloaded to 2'b11.
// [RULE23] Good event decrements the fail counter and increments the question counter.
// [RULE24] All four answers inside Window-1 set early answer and bad event flags.
// [RULE25] Markov taps and reference logic follow the feedback and polynomial selects.
// [RULE26] Window-1 end, Window-2 end and sequence start arrive as one-cycle inputs.
package wdqa_pkg;

  localparam logic [1:0] WDQA_CNT_START = 2'h3;
  localparam logic [1:0] WDQA_CNT_LAST = 2'h0;

  // Status word layout
  localparam int WDQA_IDX_QST_LSB = 0;
  localparam int WDQA_IDX_CNT_LSB = 4;
  localparam int WDQA_IDX_RSVD_BIT = 6;

  // Clear vector bit positions, write-one-to-clear
  localparam int WDQA_CLR_ANSW_ERR = 0;
  localparam int WDQA_CLR_TIMEOUT = 1;
  localparam int WDQA_CLR_EARLY = 2;
  localparam int WDQA_CLR_SEQ_ERR = 3;
  localparam int WDQA_CLR_W = 4;

  // Reference answer masks per question bit, and per answer index
  localparam logic [7:0] WDQA_REF_BASE = 8'hff;
  localparam logic [7:0] WDQA_REF_Q0 = 8'h4f;
  localparam logic [7:0] WDQA_REF_Q1 = 8'h16;
  localparam logic [7:0] WDQA_REF_Q2 = 8'h8a;
  localparam logic [7:0] WDQA_REF_Q3 = 8'h2d;
  localparam logic [7:0] WDQA_REF_A3 = 8'h00;
  localparam logic [7:0] WDQA_REF_A2 = 8'hf0;
  localparam logic [7:0] WDQA_REF_A1 = 8'h0f;
  localparam logic [7:0] WDQA_REF_A0 = 8'hff;

  localparam logic [3:0] WDQA_QST_RESET = 4'h0;
  localparam logic [3:0] WDQA_MKV_RESET = 4'h0;
  localparam logic [3:0] WDQA_MKV_KICK = 4'h1;
  localparam logic [3:0] WDQA_QCNT_MAX = 4'hf;
  localparam logic [1:0] WDQA_SEL_DEFAULT = 2'h0;

  typedef enum logic [3:0] {
    WDQA_LONG = 4'h1,
    WDQA_WIN1 = 4'h2,
    WDQA_WIN2 = 4'h4,
    WDQA_GAP  = 4'h8
  } wdqa_state_t;

endpackage

// >>> shared/wdqa_q_if.sv
// Internal link between sequence control, question generator and reference logic.
`timescale 1ns/1ps
interface wdqa_q_if;
  logic init;
  logic advance;
  logic [1:0] poly_sel;
  logic [1:0] fdbk_sel;
  logic [1:0] ans_idx;
  logic [3:0] question;
  logic [7:0] ref_byte;

  modport gen (input init, input advance, input poly_sel, output question);
  modport refer (input question, input ans_idx, input fdbk_sel, output ref_byte);
  modport user (output init, output advance, output poly_sel, output fdbk_sel,
                output ans_idx, input question, input ref_byte);
endinterface

// >>> test/tb_wdqa_top.sv
// Self-checking bench for the question-answer watchdog.
`timescale 1ns/1ps
module tb_wdqa_top;
  import wdqa_pkg::*;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic seq_start = 1'b0;
  logic win1_end = 1'b0;
  logic win2_end = 1'b0;
  logic [WDQA_CLR_W-1:0] flag_clr = '0;
  logic [1:0] poly_sel = 2'h0;
  logic [1:0] fdbk_sel;
  logic ans_wr;
  logic [7:0] ans_data;
  logic [7:0] qa_index;
  logic ans_err, tmo, bad, early, seq_err, f_inc, f_dec, restart;
  logic [6:0] exp_q[$];
  logic [6:0] exp_e;
  logic [6:0] ev_now;
  logic [15:0] lfsr = 16'h70a8;
  logic [3:0] qc = 4'h0;
  logic [3:0] mk = 4'h0;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [2:0] kinds [8] = '{3'h1, 3'h5, 3'h2, 3'h3, 3'h4, 3'h0, 3'h1, 3'h0};

  always #2.5 mclk_in = ~mclk_in;

  wdqa_host host (.mclk_in(mclk_in), .ans_wr_out(ans_wr), .ans_data_out(ans_data));

  wdqa_top dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .seq_start_in(seq_start),
    .win1_end_in(win1_end), .win2_end_in(win2_end), .ans_wr_in(ans_wr),
    .ans_data_in(ans_data), .flag_clr_in(flag_clr), .fdbk_sel_in(fdbk_sel),
    .poly_sel_in(poly_sel), .qa_index_out(qa_index), .answer_error_flag_out(ans_err),
    .timeout_flag_out(tmo), .bad_event_flag_out(bad), .early_answer_flag_out(early),
    .sequence_error_flag_out(seq_err), .fail_inc_out(f_inc), .fail_dec_out(f_dec),
    .seq_restart_out(restart));

  assign ev_now = {bad, tmo, early, seq_err, ans_err, f_inc, f_dec};

  // Feedback select rotates the base byte left before the index mask
  function automatic logic [7:0] ref_b(input logic [3:0] q, input logic [1:0] i);
    logic [7:0] a;
    a = ~({8{q[0]}} & 8'h4f ^ {8{q[1]}} & 8'h16 ^ {8{q[2]}} & 8'h8a ^ {8{q[3]}} & 8'h2d);
    case (fdbk_sel)
      2'h1: a = {a[6:0], a[7]};
      2'h2: a = {a[5:0], a[7:6]};
      2'h3: a = {a[4:0], a[7:5]};
      default: a = a;
    endcase
    return a ^ {{4{~i[0]}}, {4{~i[1]}}};
  endfunction

  function automatic logic [3:0] mk_next(input logic [3:0] m);
    logic fb;
    case (poly_sel)
      2'h0: fb = m[3] ^ m[2];
      2'h1: fb = m[3] ^ m[1];
      2'h2: fb = m[3] ^ m[0];
      default: fb = m[3] ^ m[2] ^ m[1];
    endcase
    return (m == 4'h0) ? 4'h1 : {m[2:0], fb};
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic cmp_ev(input logic [6:0] e, input logic [6:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: event expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_idx(input logic [7:0] e);
    cmp_count++;
    if (qa_index !== e) begin
      n_mismatch++;
      $display("Error at %0t: index expected %h got %h", $time, e, qa_index);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic pulse(input logic first);
    @(negedge mclk_in);
    win1_end = first;
    win2_end = ~first;
    @(negedge mclk_in);
    win1_end = 1'b0;
    win2_end = 1'b0;
  endtask

  task automatic clear_flags;
    @(negedge mclk_in);
    flag_clr = '1;
    @(negedge mclk_in);
    flag_clr = '0;
  endtask

  // Bench keeps its own question counter and Markov state
  task automatic run_seq(input logic [2:0] k);
    logic [3:0] q;
    logic [7:0] b;
    logic [7:0] r;
    int n;
    q = qc ^ mk;
    lfsr = lfsr_next(lfsr);
    r = lfsr[7:0] | 8'h01;
    cmp_idx({4'h3, q});
    case (k)
      3'h0: exp_q.push_back(7'h01);
      3'h2: exp_q.push_back(7'h52);
      3'h3: exp_q.push_back(7'h6a);
      3'h4: exp_q.push_back(7'h62);
      default: exp_q.push_back(7'h46);
    endcase
    for (int i = 3; i >= 0; i--) begin
      if (i == 0 && k != 3'h2) pulse(1'b1);
      if (k == 3'h0 && i == 2) clear_flags;
      if (i == 0 && (k == 3'h3 || k == 3'h4)) pulse(1'b0);
      else if (k != 3'h3 || i == 3) begin
        b = ref_b(q, i[1:0]);
        if (k == 3'h1 && i[1:0] == lfsr[9:8]) b = b ^ r;
        if (k == 3'h5 && i >= 2) b = ref_b(q, i[1:0] ^ 2'h1);
        host.send(b);
        if (k == 3'h0 && i == 3) cmp_idx({4'h2, q});
      end
    end
    n = 0;
    while (restart !== 1'b1 && n < 40) begin
      @(negedge mclk_in);
      n++;
    end
    if (n >= 40) begin
      n_mismatch++;
      $display("Error at %0t: restart wait %h of %h", $time, n, 40);
      report_and_stop;
    end
    clear_flags;
    if (k == 3'h0) begin
      if (qc == 4'hf) mk = mk_next(mk);
      qc = qc + 4'h1;
    end
  endtask

  // Outputs are read mid-cycle, where the one-cycle pulses are settled
  always @(negedge mclk_in) begin
    if (f_inc === 1'b1 || f_dec === 1'b1) begin
      exp_e = exp_q.size() > 0 ? exp_q.pop_front() : 7'h00;
      cmp_ev(exp_e, ev_now);
    end
  end

  initial begin
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in);
    lfsr = lfsr_next(lfsr);
    poly_sel = lfsr[15:14];
    fdbk_sel = lfsr[13:12];
    arst_n_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    cmp_idx(8'h30);
    seq_start = 1'b1;
    @(negedge mclk_in);
    seq_start = 1'b0;
    for (int t = 0; t < 41; t++) begin
      run_seq(t < 33 ? 3'h0 : kinds[t - 33]);
      $display("Test %0d done", t);
    end
    repeat (4) @(posedge mclk_in);
    report_and_stop;
  end
endmodule

// >>> test/wdqa_assertions.sv
// Port checks for the question-answer watchdog.
`timescale 1ns/1ps
module wdqa_assertions (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ans_wr_in,
  input wire logic win2_end_in,
  input wire logic [wdqa_pkg::WDQA_CLR_W-1:0] flag_clr_in,
  input wire logic [7:0] qa_index_out,
  input wire logic answer_error_flag_out,
  input wire logic timeout_flag_out,
  input wire logic bad_event_flag_out,
  input wire logic early_answer_flag_out,
  input wire logic fail_inc_out,
  input wire logic fail_dec_out,
  input wire logic seq_restart_out
);
  import wdqa_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_seq_end;
    fail_inc_out || fail_dec_out;
  endsequence
  sequence s_restart;
    seq_restart_out && qa_index_out[5:4] == WDQA_CNT_START;
  endsequence
  chk_next_seq: assert property (s_seq_end |=> s_restart)
    else $error("no restart one cycle after sequence end");
  chk_rsvd_bits: assert property (qa_index_out[7:6] == 2'h0)
    else $error("reserved index bits not zero");
  chk_bad_kept: assert property (fail_inc_out |-> bad_event_flag_out && !fail_dec_out)
    else $error("fail increment without bad event");
  chk_good_clean: assert property (fail_dec_out |-> !bad_event_flag_out)
    else $error("good event with bad flag");
  chk_question_hold: assert property (fail_inc_out |=> $stable(qa_index_out[3:0]) [*4])
    else $error("question changed after bad event");
  // Question lags the good event by the qgen flop and the index flop
  chk_question_step: assert property
    (fail_dec_out |-> ##3 qa_index_out[3:0] != $past(qa_index_out[3:0], 3))
    else $error("question not advanced after good event");
  chk_err_sticky: assert property
    (answer_error_flag_out && !flag_clr_in[WDQA_CLR_ANSW_ERR] |=> answer_error_flag_out)
    else $error("answer error flag lost without clear");
  chk_err_cause: assert property ($rose(answer_error_flag_out) |-> $past(ans_wr_in))
    else $error("answer error without a write");
  chk_timeout_cause: assert property
    ($rose(timeout_flag_out) |-> $past(win2_end_in) && fail_inc_out)
    else $error("timeout without window-2 end");
  chk_early_cause: assert property
    ($rose(early_answer_flag_out) |-> $past(ans_wr_in) && fail_inc_out)
    else $error("early flag without final write");
endmodule

bind wdqa_top wdqa_assertions u_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
  .ans_wr_in(ans_wr_in), .win2_end_in(win2_end_in), .flag_clr_in(flag_clr_in),
  .qa_index_out(qa_index_out), .answer_error_flag_out(answer_error_flag_out),
  .timeout_flag_out(timeout_flag_out), .bad_event_flag_out(bad_event_flag_out),
  .early_answer_flag_out(early_answer_flag_out), .fail_inc_out(fail_inc_out),
  .fail_dec_out(fail_dec_out), .seq_restart_out(seq_restart_out));

// >>> test/wdqa_host.sv
// Host model writing answer bytes one at a time.
`timescale 1ns/1ps
module wdqa_host (
  input wire logic mclk_in,
  output logic ans_wr_out,
  output logic [7:0] ans_data_out
);
  initial begin
    ans_wr_out = 1'b0;
    ans_data_out = 8'h5a;
  end
  // Released data shows the inverse, so a stale byte never passes
  task automatic send(input logic [7:0] b);
    @(negedge mclk_in);
    ans_wr_out = 1'b1;
    ans_data_out = b;
    @(negedge mclk_in);
    ans_wr_out = 1'b0;
    ans_data_out = ~b;
  endtask
endmodule
